// File: hw/rcpd_consts.svh
// rcpd_consts.svh: codes, pin encodings and reset defaults of the reset configuration decoder
// assumes: included by the design modules rcpd_decode and rcpd_top, not by the package; definitions only
`ifndef RCPD_CONSTS_SVH
`define RCPD_CONSTS_SVH

// ----------------------------------------------------------------------
// pin encodings as sampled during reset
// ----------------------------------------------------------------------
`define RCPD_CFG_ENABLED 1'b0
`define RCPD_BW_PIN_32A 2'b00
`define RCPD_BW_PIN_16 2'b01
`define RCPD_BW_PIN_8 2'b10
`define RCPD_BW_PIN_32B 2'b11
`define RCPD_DRIVE_PIN_FULL 1'b1
`define RCPD_SEL_PIN_3ADDR 2'b00
`define RCPD_SEL_PIN_1CS 2'b10
`define RCPD_SEL_PIN_2CS 2'b01
`define RCPD_SEL_PIN_3CS 2'b11

// ----------------------------------------------------------------------
// chip select masks for upper_address_lines, bit 2 is the top pin
// ----------------------------------------------------------------------
`define RCPD_CS_MASK_NONE 3'h0
`define RCPD_CS_MASK_1CS 3'h4
`define RCPD_CS_MASK_2CS 3'h6
`define RCPD_CS_MASK_3CS 3'h7

// ----------------------------------------------------------------------
// defaults when pin configuration is off, and reset values
// ----------------------------------------------------------------------
`define RCPD_DEF_PAD_FULL 1'b0
`define RCPD_RST_PINS 8'hff

`endif

// File: hw/rcpd_pkg.sv
// rcpd_pkg.sv: types of the reset configuration decoder
// assumes: nothing outside this file; rcpd_consts.svh is not included here
package rcpd_pkg;

	// ----------------------------------------------------------------------
	// decoded settings
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		RCPD_BOOT_W32 = 2'b00,
		RCPD_BOOT_W16 = 2'b01,
		RCPD_BOOT_W8 = 2'b10
	} rcpd_boot_width_t;

	typedef enum logic [1:0] {
		RCPD_CLK_EXT_NO_PLL = 2'b00,
		RCPD_CLK_PLL_1TO1 = 2'b01,
		RCPD_CLK_PLL_EXT_REF = 2'b10,
		RCPD_CLK_PLL_XTAL = 2'b11
	} rcpd_clock_mode_t;

	typedef enum logic [1:0] {
		RCPD_ADDR_3A = 2'b00,
		RCPD_ADDR_1CS_2A = 2'b01,
		RCPD_ADDR_2CS_1A = 2'b10,
		RCPD_ADDR_3CS = 2'b11
	} rcpd_addr_use_t;

	typedef enum logic [0:0] {
		RCPD_ST_CAPTURE = 1'b0,
		RCPD_ST_LOCKED = 1'b1
	} rcpd_state_t;

	// ----------------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic config_enable_n;
		logic [1:0] boot_width_pins;
		logic pad_drive_pin;
		logic clock_mode_hi;
		logic clock_mode_lo;
		logic [1:0] select_line_choice_pins;
	} rcpd_pins_t;

	typedef struct packed {
		logic pin_config_used;
		rcpd_boot_width_t boot_width;
		logic pad_full_drive;
		rcpd_clock_mode_t clock_mode;
		rcpd_addr_use_t addr_use;
		logic [2:0] cs_mask;
	} rcpd_settings_t;

endpackage

// File: hw/rcpd_decode.sv
// rcpd_decode.sv: combinational decode of captured configuration pins into settings
// assumes: its input is already frozen by the caller, it holds no state
`timescale 1ns/100ps
`default_nettype none
`include "rcpd_consts.svh"

module rcpd_decode import rcpd_pkg::*; (
	input wire rcpd_pins_t pins_i,
	output var rcpd_settings_t settings_o
);

	function automatic rcpd_boot_width_t rcpd_boot_f(input logic [1:0] code);
		case (code)
			`RCPD_BW_PIN_8: rcpd_boot_f = RCPD_BOOT_W8;
			`RCPD_BW_PIN_16: rcpd_boot_f = RCPD_BOOT_W16;
			default: rcpd_boot_f = RCPD_BOOT_W32;
		endcase
	endfunction

	function automatic rcpd_addr_use_t rcpd_addr_f(input logic [1:0] code);
		case (code)
			`RCPD_SEL_PIN_1CS: rcpd_addr_f = RCPD_ADDR_1CS_2A;
			`RCPD_SEL_PIN_2CS: rcpd_addr_f = RCPD_ADDR_2CS_1A;
			`RCPD_SEL_PIN_3CS: rcpd_addr_f = RCPD_ADDR_3CS;
			default: rcpd_addr_f = RCPD_ADDR_3A;
		endcase
	endfunction

	function automatic logic [2:0] rcpd_mask_f(input rcpd_addr_use_t use_v);
		case (use_v)
			RCPD_ADDR_1CS_2A: rcpd_mask_f = `RCPD_CS_MASK_1CS;
			RCPD_ADDR_2CS_1A: rcpd_mask_f = `RCPD_CS_MASK_2CS;
			RCPD_ADDR_3CS: rcpd_mask_f = `RCPD_CS_MASK_3CS;
			default: rcpd_mask_f = `RCPD_CS_MASK_NONE;
		endcase
	endfunction

	logic enabled;
	rcpd_addr_use_t addr_use;

	always_comb begin
		enabled = (pins_i.config_enable_n == `RCPD_CFG_ENABLED);
		addr_use = enabled ? rcpd_addr_f(pins_i.select_line_choice_pins) : RCPD_ADDR_3A;
		settings_o.pin_config_used = enabled;
		// boot width reads back as 32-bit unless the pins chose otherwise
		settings_o.boot_width = enabled ? rcpd_boot_f(pins_i.boot_width_pins) : RCPD_BOOT_W32;
		settings_o.pad_full_drive = enabled ? (pins_i.pad_drive_pin == `RCPD_DRIVE_PIN_FULL)
			: `RCPD_DEF_PAD_FULL;
		// clock mode pins are dedicated, so they apply whatever the enable says
		settings_o.clock_mode = rcpd_clock_mode_t'({pins_i.clock_mode_hi, pins_i.clock_mode_lo});
		settings_o.addr_use = addr_use;
		settings_o.cs_mask = rcpd_mask_f(addr_use);
	end

endmodule
`default_nettype wire

// File: hw/rcpd_top.sv
// rcpd_top.sv: reset-time capture of the configuration pins and the held, decoded settings
// assumes: one 25 MHz clock, synchronous active-high reset; pins are synchronous to the clock
`timescale 1ns/100ps
`default_nettype none
`include "rcpd_consts.svh"

module rcpd_top import rcpd_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic config_enable_n_i,
	input wire logic [1:0] boot_width_pins_i,
	input wire logic pad_drive_pin_i,
	input wire logic clock_mode_hi_i,
	input wire logic clock_mode_lo_i,
	input wire logic [1:0] select_line_choice_pins_i,
	output var rcpd_settings_t settings_o,
	output logic config_valid_o
);

	// ----------------------------------------------------------------------
	// capture state
	// ----------------------------------------------------------------------
	rcpd_pins_t live_pins;
	rcpd_pins_t pins_ff;
	rcpd_pins_t nxt_pins;
	rcpd_state_t state_ff;
	rcpd_state_t nxt_state;
	rcpd_settings_t settings_ff;
	rcpd_settings_t nxt_settings;
	rcpd_settings_t decoded;
	rcpd_settings_t default_settings;

	assign live_pins = '{
		config_enable_n: config_enable_n_i,
		boot_width_pins: boot_width_pins_i,
		pad_drive_pin: pad_drive_pin_i,
		clock_mode_hi: clock_mode_hi_i,
		clock_mode_lo: clock_mode_lo_i,
		select_line_choice_pins: select_line_choice_pins_i
	};

	// settings shown while reset is held: the disabled-configuration defaults, with clock mode set to external without PLL
	assign default_settings = '{
		pin_config_used: 1'b0,
		boot_width: RCPD_BOOT_W32,
		pad_full_drive: `RCPD_DEF_PAD_FULL,
		clock_mode: RCPD_CLK_EXT_NO_PLL,
		addr_use: RCPD_ADDR_3A,
		cs_mask: `RCPD_CS_MASK_NONE
	};

	rcpd_decode u_decode (
		.pins_i(pins_ff),
		.settings_o(decoded)
	);

	// ----------------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------------
	// pins are resampled on every reset edge, so the last edge before release wins;
	// glitches earlier in reset do no harm as long as the pins settle before release
	always_comb begin
		nxt_pins = pins_ff;
		nxt_state = state_ff;
		nxt_settings = settings_ff;
		case (state_ff)
			RCPD_ST_CAPTURE: begin
				if (!srst_i) begin
					nxt_state = RCPD_ST_LOCKED;
					nxt_settings = decoded;
				end
			end
			RCPD_ST_LOCKED: begin
				nxt_state = RCPD_ST_LOCKED;
			end
			default: begin
				nxt_state = RCPD_ST_CAPTURE;
			end
		endcase
		if (srst_i) begin
			nxt_pins = live_pins;
			nxt_state = RCPD_ST_CAPTURE;
			nxt_settings = default_settings;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		state_ff <= nxt_state;
		pins_ff <= nxt_pins;
		settings_ff <= nxt_settings;
	end

	assign settings_o = settings_ff;
	assign config_valid_o = (state_ff == RCPD_ST_LOCKED);

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	logic past_valid_ff;
	logic nxt_past_valid;

	always_comb begin
		nxt_past_valid = config_valid_o && !srst_i;
	end

	always_ff @(posedge sys_clk_i) begin
		past_valid_ff <= nxt_past_valid;
	end

	property p_disabled_cfg;
		@(posedge sys_clk_i) disable iff (srst_i)
		(config_valid_o && pins_ff.config_enable_n) |-> !settings_o.pin_config_used;
	endproperty
	a_disabled_cfg: assert property (p_disabled_cfg) else $error("pin configuration used while disabled");

	property p_enabled_cfg;
		@(posedge sys_clk_i) disable iff (srst_i)
		(config_valid_o && !pins_ff.config_enable_n) |-> settings_o.pin_config_used;
	endproperty
	a_enabled_cfg: assert property (p_enabled_cfg) else $error("pin configuration ignored while enabled");

	property p_boot_decode;
		@(posedge sys_clk_i) disable iff (srst_i)
		(config_valid_o && !pins_ff.config_enable_n) |->
			(settings_o.boot_width == ((pins_ff.boot_width_pins == `RCPD_BW_PIN_8) ? RCPD_BOOT_W8 :
			(pins_ff.boot_width_pins == `RCPD_BW_PIN_16) ? RCPD_BOOT_W16 : RCPD_BOOT_W32));
	endproperty
	a_boot_decode: assert property (p_boot_decode) else $error("boot width decoded wrongly");

	property p_boot_default;
		@(posedge sys_clk_i) disable iff (srst_i)
		(config_valid_o && pins_ff.config_enable_n) |-> (settings_o.boot_width == RCPD_BOOT_W32);
	endproperty
	a_boot_default: assert property (p_boot_default) else $error("boot width default not 32-bit");

	property p_drive_decode;
		@(posedge sys_clk_i) disable iff (srst_i)
		(config_valid_o && !pins_ff.config_enable_n) |->
			(settings_o.pad_full_drive == (pins_ff.pad_drive_pin == `RCPD_DRIVE_PIN_FULL));
	endproperty
	a_drive_decode: assert property (p_drive_decode) else $error("pad drive decoded wrongly");

	property p_drive_default;
		@(posedge sys_clk_i) disable iff (srst_i)
		(config_valid_o && pins_ff.config_enable_n) |-> (settings_o.pad_full_drive == `RCPD_DEF_PAD_FULL);
	endproperty
	a_drive_default: assert property (p_drive_default) else $error("pad drive default not partial");

	property p_clock_decode;
		@(posedge sys_clk_i) disable iff (srst_i)
		config_valid_o |-> (settings_o.clock_mode == {pins_ff.clock_mode_hi, pins_ff.clock_mode_lo});
	endproperty
	a_clock_decode: assert property (p_clock_decode) else $error("clock mode decoded wrongly");

	property p_select_decode;
		@(posedge sys_clk_i) disable iff (srst_i)
		(config_valid_o && !pins_ff.config_enable_n) |->
			(settings_o.cs_mask == ((pins_ff.select_line_choice_pins == `RCPD_SEL_PIN_1CS) ? `RCPD_CS_MASK_1CS :
			(pins_ff.select_line_choice_pins == `RCPD_SEL_PIN_2CS) ? `RCPD_CS_MASK_2CS :
			(pins_ff.select_line_choice_pins == `RCPD_SEL_PIN_3CS) ? `RCPD_CS_MASK_3CS : `RCPD_CS_MASK_NONE));
	endproperty
	a_select_decode: assert property (p_select_decode) else $error("chip select use decoded wrongly");

	property p_addr_default;
		@(posedge sys_clk_i) disable iff (srst_i)
		(config_valid_o && pins_ff.config_enable_n) |->
			(settings_o.addr_use == RCPD_ADDR_3A && settings_o.cs_mask == `RCPD_CS_MASK_NONE);
	endproperty
	a_addr_default: assert property (p_addr_default) else $error("upper pins not address lines by default");

	property p_release_valid;
		@(posedge sys_clk_i)
		(srst_i ##1 !srst_i) |-> (!config_valid_o ##1 config_valid_o);
	endproperty
	a_release_valid: assert property (p_release_valid) else $error("settings not valid one edge after release");

	property p_hold;
		@(posedge sys_clk_i) disable iff (srst_i)
		(past_valid_ff && config_valid_o) |-> ($stable(settings_o) && $stable(pins_ff));
	endproperty
	a_hold: assert property (p_hold) else $error("settings changed outside reset");

	property p_reset_clears;
		@(posedge sys_clk_i)
		srst_i |=> (!config_valid_o && !settings_o.pin_config_used);
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset did not return to capture");

	property p_capture_last;
		@(posedge sys_clk_i)
		srst_i |=> (pins_ff == $past(live_pins));
	endproperty
	a_capture_last: assert property (p_capture_last) else $error("pins not sampled during reset");

	c_enabled_8bit: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		config_valid_o && settings_o.pin_config_used && settings_o.boot_width == RCPD_BOOT_W8);
	c_disabled: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		config_valid_o && !settings_o.pin_config_used);
	c_three_cs: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		config_valid_o && settings_o.addr_use == RCPD_ADDR_3CS && settings_o.pad_full_drive);
	c_pins_move_after: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		config_valid_o && (live_pins != pins_ff));

endmodule
`default_nettype wire

// File: testbench/rcpd_cfg_driver.sv
// rcpd_cfg_driver.sv: behavioural model of the board circuit that drives the configuration pins
// assumes: srst_i is the chip reset seen on the board, cfg_i holds the wanted values set by the bench
`timescale 1ns/100ps
`default_nettype none

module rcpd_cfg_driver import rcpd_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire rcpd_pins_t cfg_i,
	output var rcpd_pins_t pins_o
);
	// one process owns the pins; reset and wanted values are taken at the edge,
	// so a bench change at the same edge cannot race
	initial begin
		logic rs;
		rcpd_pins_t c;
		pins_o = '1;
		forever begin
			@(posedge sys_clk_i);
			rs = srst_i;
			c = cfg_i;
			#1;
			if (rs) begin
				pins_o = c;
			end else begin
				// released data bus: pins wander every cycle so a late capture cannot hide
				pins_o = ~pins_o;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/rcpd_top_tb.sv
// rcpd_top_tb.sv: self-checking bench of the reset configuration decoder
// assumes: rcpd_cfg_driver model on the pins, 25 MHz clock, expected values noted in a queue
`timescale 1ns/100ps
`default_nettype none

module rcpd_top_tb import rcpd_pkg::*; ;
	logic sys_clk = 1'b0;
	logic srst;
	logic valid;
	logic rs_last = 1'b1;
	logic have = 1'b0;
	int error_cnt;
	int cmp_count;
	int cyc = 0;
	integer seed = 32'h1c1e0333;
	rcpd_pins_t cfg;
	rcpd_pins_t pins;
	rcpd_settings_t settings;
	rcpd_settings_t cur;
	rcpd_settings_t exp_q[$];

	always #20 sys_clk = ~sys_clk;

	rcpd_cfg_driver u_rcpd_cfg_driver (.sys_clk_i(sys_clk), .srst_i(srst), .cfg_i(cfg), .pins_o(pins));

	rcpd_top u_rcpd_top (
		.sys_clk_i(sys_clk),
		.srst_i(srst),
		.config_enable_n_i(pins.config_enable_n),
		.boot_width_pins_i(pins.boot_width_pins),
		.pad_drive_pin_i(pins.pad_drive_pin),
		.clock_mode_hi_i(pins.clock_mode_hi),
		.clock_mode_lo_i(pins.clock_mode_lo),
		.select_line_choice_pins_i(pins.select_line_choice_pins),
		.settings_o(settings),
		.config_valid_o(valid)
	);

	// ----------------------------------------------------------------------
	// expected settings and compares
	// ----------------------------------------------------------------------
	function automatic rcpd_settings_t expect_of(input rcpd_pins_t p);
		rcpd_settings_t s;
		s = '0;
		s.clock_mode = rcpd_clock_mode_t'({p.clock_mode_hi, p.clock_mode_lo});
		if (p.config_enable_n === 1'b0) begin
			s.pin_config_used = 1'b1;
			s.pad_full_drive = p.pad_drive_pin;
			case (p.boot_width_pins)
				2'b10: s.boot_width = RCPD_BOOT_W8;
				2'b01: s.boot_width = RCPD_BOOT_W16;
				default: s.boot_width = RCPD_BOOT_W32;
			endcase
			case (p.select_line_choice_pins)
				2'b10: begin s.addr_use = RCPD_ADDR_1CS_2A; s.cs_mask = 3'h4; end
				2'b01: begin s.addr_use = RCPD_ADDR_2CS_1A; s.cs_mask = 3'h6; end
				2'b11: begin s.addr_use = RCPD_ADDR_3CS; s.cs_mask = 3'h7; end
				default: s.addr_use = RCPD_ADDR_3A;
			endcase
		end
		// disabled: stays 32-bit boot, partial drive, plain address lines
		return s;
	endfunction

	task automatic chk_set(input rcpd_settings_t e, input rcpd_settings_t a);
		cmp_count++;
		if (a !== e) begin
			error_cnt++;
			$display("ERROR %0t settings %h expected %h", $time, a, e);
		end
	endtask

	task automatic chk_bit(input logic e, input logic a, input string what);
		cmp_count++;
		if (a !== e) begin
			error_cnt++;
			$display("ERROR %0t %s is %b", $time, what, a);
		end
	endtask

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------------
	// watcher: outputs are looked at on the falling edge, where they are settled
	// ----------------------------------------------------------------------
	always @(posedge sys_clk) begin
		rs_last <= srst;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			$display("ERROR %0t run did not finish", $time);
			report_and_stop();
		end
	end

	always @(negedge sys_clk) begin
		if (cyc > 1) begin
			if (rs_last) begin
				chk_set('0, settings);
				chk_bit(1'b0, valid, "valid in reset");
				have = 1'b0;
			end else begin
				chk_bit(1'b1, valid, "valid after reset");
				if (!have) begin
					if (exp_q.size() == 0) begin
						error_cnt++;
						$display("ERROR %0t result with no note", $time);
					end else begin
						cur = exp_q.pop_front();
					end
					have = 1'b1;
				end
				chk_set(cur, settings);
			end
		end
	end

	// ----------------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------------
	// hold of at least two edges: the model takes new wanted values one edge late
	task automatic run_case(input rcpd_pins_t p, input int hold, input int stay);
		@(posedge sys_clk);
		#1;
		cfg = p;
		srst = 1'b1;
		repeat (hold) @(posedge sys_clk);
		#1;
		exp_q.push_back(expect_of(p));
		srst = 1'b0;
		repeat (stay) @(posedge sys_clk);
	endtask

	initial begin
		logic [31:0] r;
		logic [3:0] k;
		rcpd_pins_t p;
		srst = 1'b1;
		cfg = '1;
		error_cnt = 0;
		cmp_count = 0;
		run_case(8'h00, 20, 4);
		for (int i = 0; i < 16; i++) begin
			k = i[3:0];
			p = {1'b0, k[1:0], k[0] ^ k[3], k[1], k[2], k[3:2]};
			run_case(p, 2 + (i % 3), 3);
		end
		$display("test code table done");
		for (int i = 0; i < 20; i++) begin
			r = $random(seed);
			run_case(r[7:0], 2 + int'(r[9:8]), 2 + int'(r[11:10]));
		end
		$display("test random pins done");
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			p = r[7:0];
			p.config_enable_n = 1'b1;
			run_case(p, 2, 3);
		end
		$display("test disabled config done");
		report_and_stop();
	end
endmodule
`default_nettype wire
